// ### hw/fasb_alerts.sv
// Fault-monitor and alert breakout registers with AXI4-Lite slave
`timescale 1ns/1ns
`include "fasb_params.svh"
module fasb_alerts
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic [5:0]        s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [5:0]        s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire fasb_pkg::fasb_temp_t temp_i,
    input  wire fasb_pkg::fasb_acq_t  acq_i,
    input  wire logic              scan_timeout_event_i,
    input  wire logic              balance_done_i,
    output logic [1:0]             balancing_state_o,
    output logic                   irq_o
);
    import fasb_pkg::*;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [4:0]  sticky_reg;   // overtemp, zs, fs, acc_high, acc_low
    logic        scan_timeout_flag_reg;
    logic        scan_timeout_disable_reg;
    logic        selftest_enable_reg;
    logic        comparator_accuracy_enable_reg;
    logic [2:0]  scan_configuration_reg;
    logic [1:0]  balancing_state_reg;
    logic        balance_thermal_stop_alert_reg;
    logic        cell_adc_over_summary_reg;
    logic        cell_comparator_over_summary_reg;
    logic        current_sense_high_alert_reg;
    logic [6:0]  other_summ_reg;
    logic [4:0]  cal_reg;
    logic [3:0]  irq_status_reg;
    logic [3:0]  irq_mask_reg;

    // ************************************************************
    // Write channel: both address and data taken together
    // ************************************************************
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    wire         wr_go   = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
    wire  [3:0]  wr_idx  = s_axi_awaddr_i[5:2];
    wire         wr_low  = wr_go & s_axi_wstrb_i[0];
    wire         wr_high = wr_go & s_axi_wstrb_i[1];
    wire  [15:0] wd      = s_axi_wdata_i[15:0];
    wire         wr_fm2  = wr_idx == `FASB_IDX_FAULT_TWO;
    wire         wr_mapped = wr_fm2 || wr_idx == `FASB_IDX_BREAKOUT ||
                 wr_idx == `FASB_IDX_SCAN_CTRL || wr_idx == `FASB_IDX_CONFIG ||
                 wr_idx == `FASB_IDX_IRQ_STATUS ||
                 wr_idx == `FASB_IDX_IRQ_MASK || wr_idx == `FASB_IDX_BAL_CTRL;
    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o  = wr_go;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;

    // Byte-lane gated "write zero" clear masks per sticky bit
    wire clr_temp  = wr_high & wr_fm2 & ~wd[`FASB_BIT_OVERTEMP];
    wire clr_zs    = wr_low & wr_fm2 & ~wd[`FASB_BIT_ZERO_SCALE];
    wire clr_fs    = wr_low & wr_fm2 & ~wd[`FASB_BIT_FULL_SCALE];
    wire clr_acch  = wr_low & wr_fm2 & ~wd[`FASB_BIT_ACC_HIGH];
    wire clr_accl  = wr_low & wr_fm2 & ~wd[`FASB_BIT_ACC_LOW];
    wire [4:0] clr_vec = {clr_temp, clr_zs, clr_fs, clr_acch, clr_accl};

    // ************************************************************
    // Event decode
    // ************************************************************
    wire over_temp = temp_i.temp_valid &&
                     temp_i.temp_c > `FASB_TEMP_LIMIT_C;
    wire st_go     = acq_i.acq_done & selftest_enable_reg;
    wire acc_cfg   = scan_configuration_reg == `FASB_SCAN_CONFIGURATION_A ||
                     scan_configuration_reg == `FASB_SCAN_CONFIGURATION_B;
    wire acc_go    = acq_i.acq_done & acc_cfg &
                     comparator_accuracy_enable_reg;
    wire [4:0] set_vec = {over_temp,
                          st_go & acq_i.zs_fail,
                          st_go & acq_i.fs_fail,
                          acc_go & acq_i.acc_high_fail,
                          acc_go & acq_i.acc_low_fail};
    wire balancing  = balancing_state_reg == 2'h1 ||
                      balancing_state_reg == 2'h2;
    wire therm_stop = balancing & (over_temp | sticky_reg[4]);
    wire scan_to_set = scan_timeout_event_i & ~scan_timeout_disable_reg;
    wire scan_to_clr = wr_low && wr_idx == `FASB_IDX_SCAN_CTRL && ~wd[0];

    // Set beats clear so an event in the clearing cycle is kept
    wire [4:0] sticky_next = set_vec | (sticky_reg & ~clr_vec);

    // ************************************************************
    // Readback
    // ************************************************************
    wire [15:0] fm2_view = {3'h0, sticky_reg[4],
                            scan_timeout_flag_reg,
                            7'h00, sticky_reg[3:0]};
    wire [15:0] brk_view = {cell_adc_over_summary_reg,
                            cell_comparator_over_summary_reg,
                            other_summ_reg[6:1],
                            current_sense_high_alert_reg,
                            other_summ_reg[0],
                            1'b0,
                            cal_reg};
    wire [3:0]  ev_vec   = {therm_stop, scan_to_set,
                            |set_vec[3:0], set_vec[4]};
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    wire  [3:0]  rd_idx = s_axi_araddr_i[5:2];
    wire         rd_go  = s_axi_arvalid_i & ~rvalid_reg;
    logic [15:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (rd_idx)
            `FASB_IDX_FAULT_TWO:  rd_mux = fm2_view;
            `FASB_IDX_BREAKOUT:   rd_mux = brk_view;
            `FASB_IDX_SCAN_CTRL:  rd_mux = {14'h0000,
                                   scan_timeout_disable_reg,
                                   scan_timeout_flag_reg};
            `FASB_IDX_CONFIG:     rd_mux = {11'h000, scan_configuration_reg,
                                   comparator_accuracy_enable_reg,
                                   selftest_enable_reg};
            `FASB_IDX_IRQ_STATUS: rd_mux = {12'h000, irq_status_reg};
            `FASB_IDX_IRQ_MASK:   rd_mux = {12'h000, irq_mask_reg};
            `FASB_IDX_BAL_CTRL:   rd_mux = {13'h0000,
                                   balance_thermal_stop_alert_reg,
                                   balancing_state_reg};
            default: begin
                rd_mux = 16'h0000;
                rd_ok  = 1'b0;
            end
        endcase
    end
    assign s_axi_arready_o = rd_go;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign balancing_state_o = balancing_state_reg;
    assign irq_o = |(irq_status_reg & irq_mask_reg);

    // ************************************************************
    // Bus handshake registers
    // ************************************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `FASB_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `FASB_RESP_OKAY;
        end else begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? `FASB_RESP_OKAY : `FASB_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {16'h0000, rd_mux};
                rresp_reg  <= rd_ok ? `FASB_RESP_OKAY : `FASB_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Alert state
    // ************************************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sticky_reg            <= 5'h00;
            scan_timeout_flag_reg <= 1'b0;
        end else begin
            sticky_reg <= sticky_next;
            if (scan_to_set)
                scan_timeout_flag_reg <= 1'b1;
            else if (scan_to_clr)
                scan_timeout_flag_reg <= 1'b0;
        end
    end

    // Breakout summaries refresh only at their own acquisitions
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cell_adc_over_summary_reg        <= 1'b0;
            cell_comparator_over_summary_reg <= 1'b0;
            other_summ_reg                   <= 7'h00;
            cal_reg                          <= 5'h00;
            current_sense_high_alert_reg     <= 1'b0;
        end else begin
            if (acq_i.acq_done) begin
                cell_adc_over_summary_reg <= |acq_i.cell_adc_ov;
                cell_comparator_over_summary_reg <=
                    |acq_i.cell_cmp_ov;
                other_summ_reg <= acq_i.other_summ;
                cal_reg        <= acq_i.cal_alerts;
            end
            if (acq_i.csa_done)
                current_sense_high_alert_reg <= acq_i.csa_high;
        end
    end

    // ************************************************************
    // Configuration, balancing and interrupt registers
    // ************************************************************
    wire wr_cfg  = wr_low && wr_idx == `FASB_IDX_CONFIG;
    wire wr_sc   = wr_low && wr_idx == `FASB_IDX_SCAN_CTRL;
    wire wr_bal  = wr_low && wr_idx == `FASB_IDX_BAL_CTRL;
    wire wr_msk  = wr_low && wr_idx == `FASB_IDX_IRQ_MASK;
    wire wr_ist  = wr_low && wr_idx == `FASB_IDX_IRQ_STATUS;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_timeout_disable_reg       <= 1'b0;
            selftest_enable_reg            <= 1'b0;
            comparator_accuracy_enable_reg <= 1'b0;
            scan_configuration_reg         <= 3'h0;
            balancing_state_reg            <= 2'h0;
            balance_thermal_stop_alert_reg <= 1'b0;
            irq_mask_reg                   <= 4'h0;
            irq_status_reg                 <= 4'h0;
        end else begin
            if (wr_sc)
                scan_timeout_disable_reg <= wd[1];
            if (wr_cfg) begin
                selftest_enable_reg            <= wd[0];
                comparator_accuracy_enable_reg <= wd[1];
                scan_configuration_reg         <= wd[4:2];
            end
            if (therm_stop)
                balancing_state_reg <= `FASB_BAL_THERMAL_STOP;
            else if (balancing && balance_done_i)
                balancing_state_reg <= 2'h0;
            else if (wr_bal && !balancing)
                balancing_state_reg <= wd[1:0];
            if (therm_stop)
                balance_thermal_stop_alert_reg <= 1'b1;
            else if (wr_bal && !wd[2])
                balance_thermal_stop_alert_reg <= 1'b0;
            if (wr_msk)
                irq_mask_reg <= wd[3:0];
            irq_status_reg <= ev_vec |
                              (irq_status_reg & ~({4{wr_ist}} & wd[3:0]));
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    overtemp_sets_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) over_temp |=> fm2_view[`FASB_BIT_OVERTEMP])
        else $error("overtemp alert not set");
    write_one_keeps_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (sticky_reg[4] && !clr_temp) |=> sticky_reg[4])
        else $error("sticky alert lost without zero write");
    zero_clears_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (clr_zs && !set_vec[3]) |=> !sticky_reg[3])
        else $error("zero write did not clear");
    thermal_stop_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) therm_stop |=>
        balancing_state_o == `FASB_BAL_THERMAL_STOP &&
        balance_thermal_stop_alert_reg)
        else $error("balancing not stopped on thermal alert");
    timeout_mirror_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (rd_go && rd_idx == `FASB_IDX_FAULT_TWO) |=>
        s_axi_rdata_o[`FASB_BIT_SCAN_TO] == $past(scan_timeout_flag_reg))
        else $error("timeout alert differs from flag");
    timeout_set_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) scan_to_set |=> fm2_view[`FASB_BIT_SCAN_TO])
        else $error("timeout alert not raised");
    selftest_gate_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (!sticky_reg[3] && !selftest_enable_reg) |=> !sticky_reg[3])
        else $error("zero-scale alert set while disabled");
    fullscale_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (st_go && acq_i.fs_fail) |=> sticky_reg[2])
        else $error("full-scale failure not recorded");
    acc_gate_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!sticky_reg[1] && !(acc_cfg &&
        comparator_accuracy_enable_reg)) |=> !sticky_reg[1])
        else $error("accuracy high set outside config");
    acc_low_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (acc_go && acq_i.acc_low_fail) |=> sticky_reg[0])
        else $error("accuracy low failure not recorded");
    wire [1:0] cell_ov_now = {|acq_i.cell_adc_ov, |acq_i.cell_cmp_ov};
    cell_summary_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        acq_i.acq_done |=> brk_view[15:14] == $past(cell_ov_now))
        else $error("cell summaries wrong");
    csa_hold_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !acq_i.csa_done |=> $stable(brk_view[7]))
        else $error("current alert moved without acquisition");
    bit5_zero_a: assert property (@(posedge core_clk_i)
        disable iff (rst_i)
        (rd_go && rd_idx == `FASB_IDX_BREAKOUT) |=> !s_axi_rdata_o[5])
        else $error("breakout bit 5 not zero");
    cov_thermal_c: cover property (@(posedge core_clk_i) therm_stop);
    cov_timeout_c: cover property (@(posedge core_clk_i) scan_to_clr);
    cov_irq_c: cover property (@(posedge core_clk_i) irq_o);
endmodule : fasb_alerts

// ### hw/fasb_params.svh
// Register offsets, field positions, limits and response codes of the alert block
`ifndef FASB_PARAMS_SVH
`define FASB_PARAMS_SVH
// Register indices; the byte address on the bus is the index times four
`define FASB_IDX_FAULT_TWO    4'h6
`define FASB_IDX_BREAKOUT     4'h7
`define FASB_IDX_SCAN_CTRL    4'h8
`define FASB_IDX_CONFIG       4'h9
`define FASB_IDX_IRQ_STATUS   4'hA
`define FASB_IDX_IRQ_MASK     4'hB
`define FASB_IDX_BAL_CTRL     4'hC
`define FASB_BIT_OVERTEMP     12
`define FASB_BIT_SCAN_TO      11
`define FASB_BIT_ZERO_SCALE   3
`define FASB_BIT_FULL_SCALE   2
`define FASB_BIT_ACC_HIGH     1
`define FASB_BIT_ACC_LOW      0
`define FASB_BIT_CELL_ADC_OV  15
`define FASB_BIT_CELL_CMP_OV  14
`define FASB_BIT_CSA_HIGH     7
`define FASB_TEMP_LIMIT_C     12'd115
`define FASB_SCAN_CONFIGURATION_A        3'h1
`define FASB_SCAN_CONFIGURATION_B        3'h2
`define FASB_BAL_THERMAL_STOP 2'h3
`define FASB_RESP_OKAY        2'h0
`define FASB_RESP_SLVERR      2'h2
`endif

// ### hw/fasb_pkg.sv
// Types shared by the alert block
package fasb_pkg;
    typedef struct packed {
        logic        acq_done;      // End of an acquisition
        logic        zs_fail;       // Zero-scale self-test failed
        logic        fs_fail;       // Full-scale self-test failed
        logic        acc_high_fail; // Comparator accuracy high failed
        logic        acc_low_fail;  // Comparator accuracy low failed
        logic [13:0] cell_adc_ov;   // Per-cell ADC overvoltage
        logic [13:0] cell_cmp_ov;   // Per-cell comparator overvoltage
        logic        csa_done;      // Current-sense acquisition finished
        logic        csa_high;      // Current above high threshold
        logic [6:0]  other_summ;    // Bits 13:8 and 6 of the breakout
        logic [4:0]  cal_alerts;    // Calibration alerts, bits 4:0
    } fasb_acq_t;
    typedef struct packed {
        logic        temp_valid;
        logic [11:0] temp_c;
    } fasb_temp_t;
endpackage : fasb_pkg

// ### verification/tb_fault_alert_summary_bits.sv
// Self-checking bench of the fault and alert register block
`timescale 1ns/1ns
module tb_fault_alert_summary_bits;
    import fasb_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk = 1'b0, rst = 1'b1;
    logic [5:0]  awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1, sto = 1'b0, bdone = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hF;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp, bstate;
    wire  [31:0] rdata;
    fasb_temp_t  temp = '0;
    fasb_acq_t   acq = '0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          n_errors = 0, n_tests = 0, seed = 37;
    always #10 clk = ~clk;
    fasb_alerts dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .temp_i(temp), .acq_i(acq),
        .scan_timeout_event_i(sto), .balance_done_i(bdone),
        .balancing_state_o(bstate), .irq_o(irq));
    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // Responses are matched in issue order against the noted expectations
    always @(posedge clk) begin
        if (rvalid && rready)
            check("read", {rresp, rdata}, rq.pop_front());
        if (bvalid && bready)
            check("bresp", 34'(bresp), 34'(bq.pop_front()));
    end
    task automatic wr(input logic [5:0] a, input logic [15:0] d,
                      input logic [1:0] r = 2'h0);
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge clk); while (!bvalid);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e,
                      input logic [1:0] r = 2'h0);
        rq.push_back({r, 16'h0000, e});
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
    endtask : rd
    // Outputs are looked at mid-cycle, away from register updates
    task automatic ck(string name, logic [1:0] seen_now, logic [1:0] e);
        @(negedge clk);
        if (name == "irq") check(name, 34'(irq), 34'(e));
        else check(name, 34'(bstate), 34'(e));
        @(posedge clk);
    endtask : ck
    task automatic pulse();
        acq.acq_done <= 1'b1;
        acq.csa_done <= 1'b1;
        @(posedge clk);
        acq.acq_done <= 1'b0;
        acq.csa_done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic set_temp(input logic [11:0] t);
        temp <= '{1'b1, t};
        repeat (3) @(posedge clk);
    endtask : set_temp
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [63:0] r;
        logic [15:0] e;
        fasb_acq_t   v;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(6'h18, 16'h0000);
        rd(6'h1C, 16'h0000);
        rd(6'h3C, 16'h0000, 2'h2);
        wr(6'h3C, 16'hFFFF, 2'h2);
        set_temp(12'd115);
        rd(6'h18, 16'h0000);
        set_temp(12'd116);
        rd(6'h18, 16'h1000);
        ck("irq", 2'b0, 2'b0);
        wr(6'h2C, 16'h0001);
        ck("irq", 2'b0, 2'b1);
        wr(6'h2C, 16'h0000);
        ck("irq", 2'b0, 2'b0);
        wr(6'h2C, 16'h0001);
        set_temp(12'd25);
        wr(6'h28, 16'h000F);
        ck("irq", 2'b0, 2'b0);
        wr(6'h18, 16'hFFFF);
        rd(6'h18, 16'h1000);
        wr(6'h18, 16'h0000);
        rd(6'h18, 16'h0000);
        wr(6'h30, 16'h0001);
        ck("bal", 2'b0, 2'h1);
        set_temp(12'd200);
        ck("bal", 2'b0, 2'h3);
        set_temp(12'd25);
        wstrb <= 4'h1;
        wr(6'h18, 16'h0000);
        wstrb <= 4'hF;
        rd(6'h18, 16'h1000);
        wr(6'h18, 16'h0000);
        wr(6'h28, 16'h000F);
        sto <= 1'b1;
        @(posedge clk);
        sto <= 1'b0;
        repeat (2) @(posedge clk);
        rd(6'h18, 16'h0800);
        rd(6'h20, 16'h0001);
        wr(6'h18, 16'h0000);
        rd(6'h18, 16'h0800);
        wr(6'h20, 16'h0000);
        rd(6'h18, 16'h0000);
        acq.zs_fail <= 1'b1;
        acq.fs_fail <= 1'b1;
        pulse();
        rd(6'h18, 16'h0000);
        wr(6'h24, 16'h0001);
        pulse();
        rd(6'h18, 16'h000C);
        acq.zs_fail <= 1'b0;
        acq.fs_fail <= 1'b0;
        pulse();
        rd(6'h18, 16'h000C);
        wr(6'h18, 16'h0000);
        acq.acc_high_fail <= 1'b1;
        acq.acc_low_fail  <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(6'h24, 16'((c << 2) | 2));
            pulse();
            rd(6'h18, (c == 1 || c == 2) ? 16'h0003 : 16'h0000);
            wr(6'h18, 16'h0000);
        end
        for (int i = 0; i < 6; i++) begin
            r = {$random(seed), $random(seed)};
            v = r[46:0];
            if (i == 5) v = '0;
            e = {|v.cell_adc_ov, |v.cell_cmp_ov, v.other_summ[6:1],
                 v.csa_high, v.other_summ[0], 1'b0, v.cal_alerts};
            v.acq_done = 1'b1;
            v.csa_done = 1'b1;
            acq <= v;
            @(posedge clk);
            acq <= '0;
            repeat (2) @(posedge clk);
            rd(6'h1C, e);
            wr(6'h1C, 16'hFFFF);
            rd(6'h1C, e);
        end
        report_and_stop();
    end
endmodule : tb_fault_alert_summary_bits
